/* pkg/ivmap_pkg.sv */
// ivmap_pkg: vector numbers, table offsets and the dma-clear map
// assumes: one 144-entry vector table, offsets counted down from the top word
package ivmap_pkg;
  localparam int unsigned NUM_VECTORS     = 144;
  localparam int unsigned VEC_W           = 8;
  localparam int unsigned OFS_W           = 10;
  localparam logic [9:0]  TABLE_TOP_OFS   = 10'h3FC;
  localparam logic [7:0]  FIRST_SLOT_VEC  = 8'h0C;
  localparam int unsigned NUM_SOURCES     = 30;
  // ---------------------------------------------------------------
  // source vector numbers, in source index order
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_NMI            = 8'h0B;
  localparam logic [7:0] VEC_DLY            = 8'h0C;
  localparam logic [7:0] VEC_RC_TMR         = 8'h0D;
  localparam logic [7:0] VEC_MC_TMR         = 8'h0E;
  localparam logic [7:0] VEC_SC_TMR         = 8'h0F;
  localparam logic [7:0] VEC_LOW_VOLT       = 8'h10;
  localparam logic [7:0] VEC_EXT0           = 8'h11;
  localparam logic [7:0] VEC_EXT1           = 8'h12;
  localparam logic [7:0] VEC_EXT2           = 8'h13;
  localparam logic [7:0] VEC_EXT3           = 8'h14;
  localparam logic [7:0] VEC_EXT4           = 8'h15;
  localparam logic [7:0] VEC_EXT6           = 8'h17;
  localparam logic [7:0] VEC_EXT7           = 8'h18;
  localparam logic [7:0] VEC_CAN0           = 8'h21;
  localparam logic [7:0] VEC_PULSE_GEN0     = 8'h26;
  localparam logic [7:0] VEC_RELOAD1        = 8'h3B;
  localparam logic [7:0] VEC_RELOAD2        = 8'h3C;
  localparam logic [7:0] VEC_PULSE_CLK_TMR  = 8'h40;
  localparam logic [7:0] VEC_CAPTURE0       = 8'h41;
  localparam logic [7:0] VEC_CAPTURE1       = 8'h42;
  localparam logic [7:0] VEC_CAPTURE4       = 8'h45;
  localparam logic [7:0] VEC_CAPTURE5       = 8'h46;
  localparam logic [7:0] VEC_FREE_RUN0      = 8'h59;
  localparam logic [7:0] VEC_FREE_RUN1      = 8'h5A;
  localparam logic [7:0] VEC_FLASH_BANK     = 8'h85;
  localparam logic [7:0] VEC_RANGE_CMP      = 8'h8B;
  localparam logic [7:0] VEC_PULSE_DETECT   = 8'h8C;
  localparam logic [9:0] OFS_FLASH_BANK     = 10'h1E8;
  // vector numbers of every source; pulse gen channels are 38..41
  localparam logic [7:0] SRC_VEC [NUM_SOURCES] = '{
    VEC_NMI, VEC_DLY, VEC_RC_TMR, VEC_MC_TMR, VEC_SC_TMR, VEC_LOW_VOLT,
    VEC_EXT0, VEC_EXT1, VEC_EXT2, VEC_EXT3, VEC_EXT4, VEC_EXT6, VEC_EXT7,
    VEC_CAN0, VEC_PULSE_GEN0, 8'h27, 8'h28, 8'h29, VEC_RELOAD1, VEC_RELOAD2,
    VEC_PULSE_CLK_TMR, VEC_CAPTURE0, VEC_CAPTURE1, VEC_CAPTURE4,
    VEC_CAPTURE5, VEC_FREE_RUN0, VEC_FREE_RUN1, VEC_FLASH_BANK,
    VEC_RANGE_CMP, VEC_PULSE_DETECT};
  // dma may clear: ext ints, pulse gens, reload/pulse-clock/capture/free-run timers, flash
  localparam logic [NUM_SOURCES-1:0] SRC_DMA_CLR = 30'h0FFFDFC0;
  localparam int unsigned SRC_PULSE_GEN0 = 14;
  localparam int unsigned SRC_PULSE_CLK  = 20;
  localparam int unsigned SRC_FLASH      = 27;
  localparam int unsigned SRC_RANGE_CMP  = 28;
endpackage

/* core/ivmap_encoder.sv */
// ivmap_encoder: picks the pending source with the lowest index
// assumes: pending vector is already gated by the owner
`timescale 1ns/1ps
module ivmap_encoder #(
  parameter int unsigned N = 30
) (
  input  wire logic [N-1:0] pending,
  output logic              found,
  output logic [4:0]        index
);
  always_comb begin
    found = 1'b0;
    index = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found = 1'b1;
        index = 5'(i);
      end
    end
  end
endmodule // ivmap_encoder

/* core/ivmap_core.sv */
// ivmap_core: latches peripheral requests, presents vector, offset and slot
// assumes: requests are synchronous one-cycle pulses; core acks a fetch
`timescale 1ns/1ps
module ivmap_core #(
  parameter int unsigned N = ivmap_pkg::NUM_SOURCES
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] src_req,
  input  wire logic         dma_done,
  input  wire logic [4:0]   dma_src,
  input  wire logic         fetch_ack,
  output logic              irq_valid,
  output logic [7:0]        irq_vector,
  output logic [9:0]        irq_offset,
  output logic              slot_valid,
  output logic [7:0]        priority_slot_select,
  output logic              irq_dma_clearable,
  output logic [N-1:0]      pending
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] vec_offset(input logic [7:0] v);
    vec_offset = ivmap_pkg::TABLE_TOP_OFS - {v, 2'b00};
  endfunction

  // call, reset, exception and nmi vectors sit below the first slot vector
  function automatic logic has_slot(input logic [7:0] v);
    has_slot = v >= ivmap_pkg::FIRST_SLOT_VEC;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] pend;
    logic         valid;
    logic [4:0]   src;
    logic [7:0]   vec;
    logic [9:0]   ofs;
    logic         slot_ok;
    logic [7:0]   slot;
    logic         dma_ok;
  } ivmap_state_type;

  ivmap_state_type st_q;
  ivmap_state_type st_d;
  ivmap_state_type st_nx;
  logic            found;
  logic [4:0]      pick;
  logic [N-1:0]    clr;

  // encoder sees the next pending set, so a request shows one cycle later
  ivmap_encoder #(.N(N)) u_enc (
    .pending (st_d.pend),
    .found   (found),
    .index   (pick)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // only listed sources exist, so reserved vectors cannot be raised
  always_comb begin
    clr = '0;
    // the ack names the source shown last cycle, not the one picked now
    if (fetch_ack && st_q.valid) begin
      clr[st_q.src] = 1'b1;
    end
    // out of range or non-clearable indices are ignored
    if (dma_done && dma_src < 5'(N) && ivmap_pkg::SRC_DMA_CLR[dma_src]) begin
      clr[dma_src] = 1'b1;
    end
    st_d      = st_q;
    // a new request in the clearing cycle wins over the clear
    st_d.pend = (st_q.pend & ~clr) | src_req;
  end

  // ---------------------------------------------------------------
  // output select
  // ---------------------------------------------------------------
  always_comb begin
    ivmap_state_type s;
    s         = st_d;
    s.valid   = found;
    s.src     = pick;
    s.vec     = ivmap_pkg::SRC_VEC[pick];
    s.ofs     = vec_offset(ivmap_pkg::SRC_VEC[pick]);
    s.slot_ok = found && has_slot(ivmap_pkg::SRC_VEC[pick]);
    s.slot    = s.slot_ok ? ivmap_pkg::SRC_VEC[pick] : 8'h00;
    s.dma_ok  = found && ivmap_pkg::SRC_DMA_CLR[pick];
    if (!found) begin
      s.vec = 8'h00;
      s.ofs = 10'h000;
    end
    st_nx = s;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // every output comes from st_q, so the core never sees a decode glitch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_nx;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign irq_valid            = st_q.valid;
  assign irq_vector           = st_q.vec;
  assign irq_offset           = st_q.ofs;
  assign slot_valid           = st_q.slot_ok;
  assign priority_slot_select = st_q.slot;
  assign irq_dma_clearable    = st_q.dma_ok;
  assign pending              = st_q.pend;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_offset_match: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid |-> irq_offset == 10'(10'h3FC - {irq_vector, 2'b00}))
    else $error("offset does not match vector");
  a_slot_range: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid |-> (slot_valid == (irq_vector >= 8'd12))
      && (!slot_valid || priority_slot_select == irq_vector))
    else $error("priority slot wrong");
  a_pulse_gen: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == (N'(1) << 14) && pending == '0 && !fetch_ack
      |=> irq_valid && irq_vector == 8'd38 && irq_dma_clearable)
    else $error("pulse gen channel 0 not on vector 38");
  a_pulse_clk: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == (N'(1) << 20) && pending == '0 && !fetch_ack
      |=> irq_vector == 8'd64 && irq_dma_clearable)
    else $error("pulse clock timer vector wrong");
  a_capture_dma: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid && irq_vector inside {8'd65, 8'd66, 8'd69, 8'd70} |-> irq_dma_clearable)
    else $error("capture not dma clearable");
  a_free_run: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid && irq_vector inside {8'd89, 8'd90} |-> irq_dma_clearable)
    else $error("free run not dma clearable");
  a_adc_nodma: assert property (@(posedge clk) disable iff (!reset_n)
    pending[28] && dma_done && dma_src == 5'd28 && !src_req[28]
      && !(fetch_ack && irq_valid && irq_vector == 8'd139) |=> pending[28])
    else $error("range compare cleared by dma");
  a_flash_ofs: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid && irq_vector == 8'd133 |-> irq_offset == 10'h1E8 && irq_dma_clearable)
    else $error("flash bank offset wrong");
  a_no_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid |-> !(irq_vector inside {[8'd0:8'd10], 8'd22, [8'd25:8'd32], 8'd141})
    ) else $error("reserved vector raised");
  a_dma_clear: assert property (@(posedge clk) disable iff (!reset_n)
    pending[14] && dma_done && dma_src == 5'd14 && !src_req[14] |=> !pending[14])
    else $error("dma completion did not clear");

  // ---------------------------------------------------------------
  // checks: source map
  // ---------------------------------------------------------------
  a_nmi_slot: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == N'(1) && pending == '0 && !fetch_ack
      |=> irq_valid && irq_vector == 8'h0B && !slot_valid)
    else $error("nmi shown with a priority slot");
  a_pulse_gen3: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == (N'(1) << 17) && pending == '0 && !fetch_ack
      |=> irq_valid && irq_vector == 8'h29 && irq_dma_clearable)
    else $error("pulse gen channel 3 not on vector 41");
  a_capture_zero: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == (N'(1) << 21) && pending == '0 && !fetch_ack
      |=> irq_valid && irq_vector == 8'h41 && irq_dma_clearable)
    else $error("capture unit 0 not on vector 65");
  a_capture_one: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == (N'(1) << 22) && pending == '0 && !fetch_ack
      |=> irq_valid && irq_vector == 8'h42 && irq_dma_clearable)
    else $error("capture unit 1 not on vector 66");
  a_free_run1: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == (N'(1) << 26) && pending == '0 && !fetch_ack
      |=> irq_valid && irq_vector == 8'h5A && irq_dma_clearable)
    else $error("free run timer 1 not on vector 90");
  a_flash_src: assert property (@(posedge clk) disable iff (!reset_n)
    src_req == (N'(1) << 27) && pending == '0 && !fetch_ack
      |=> irq_vector == 8'h85 && irq_offset == 10'h1E8 && irq_dma_clearable)
    else $error("flash bank source not on vector 133");
  a_range_cmp: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid && irq_vector inside {8'h8B, 8'h8C}
      |-> !irq_dma_clearable && priority_slot_select == irq_vector)
    else $error("converter source marked dma clearable");

  // ---------------------------------------------------------------
  // checks: clearing and reset
  // ---------------------------------------------------------------
  a_ack_clears: assert property (@(posedge clk) disable iff (!reset_n)
    fetch_ack && irq_valid && !src_req[st_q.src] |=> !pending[$past(st_q.src)])
    else $error("fetched source still pending");
  a_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    dma_done && dma_src < 5'(N) && src_req[dma_src] |=> pending[$past(dma_src)])
    else $error("new request lost to a dma clear");
  a_bad_index: assert property (@(posedge clk) disable iff (!reset_n)
    dma_done && dma_src >= 5'(N) && !fetch_ack && src_req == '0
      |=> pending == $past(pending))
    else $error("out of range dma index changed pending");
  a_only_pending: assert property (@(posedge clk) disable iff (!reset_n)
    irq_valid |-> pending[st_q.src]
      && (pending & ((N'(1) << st_q.src) - N'(1))) == '0)
    else $error("shown source not the lowest pending one");
  a_reset_idle: assert property (@(posedge clk)
    !reset_n && $past(reset_n) == 1'b0 |-> !irq_valid && pending == '0)
    else $error("request shown during reset");
endmodule // ivmap_core

/* tb/ivmap_core_model.sv */
// ivmap_core_model: processor core that fetches the presented vector
// assumes: drives on the falling edge, design samples on the rising edge
`timescale 1ns/1ps
module ivmap_core_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic [3:0] wait_cycles,
  input  wire logic       irq_valid,
  input  wire logic [7:0] irq_vector,
  output logic            fetch_ack,
  output logic [7:0]      last_vec
);
  logic [3:0] cnt_q;
  // one idle cycle after each ack, so a cleared source is never fetched twice
  always @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_ack <= 1'b0;
      cnt_q     <= 4'h0;
      last_vec  <= 8'h00;
    end else if (fetch_ack) begin
      fetch_ack <= 1'b0;
      cnt_q     <= 4'h0;
    end else if (enable && irq_valid) begin
      if (cnt_q == wait_cycles) begin
        fetch_ack <= 1'b1;
        last_vec  <= irq_vector;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      cnt_q <= 4'h0;
    end
  end
endmodule // ivmap_core_model

/* tb/tb_interrupt_vector_map.sv */
// tb_interrupt_vector_map: source table, dma clears, refusals and priority
// assumes: inputs change on the falling edge only
`timescale 1ns/1ps
module tb_interrupt_vector_map;
  logic        clk, reset_n, dma_done, core_en, fetch_ack, irq_valid, slot_valid, dma_clr;
  logic [29:0] src_req, pending;
  logic [4:0]  dma_src;
  logic [3:0]  wait_cycles;
  logic [7:0]  irq_vector, slot, last_vec;
  logic [9:0]  irq_offset;
  int          miscompares = 0;
  int          checks = 0;
  // expected vector and dma-clear flag of each source, in source index order
  int unsigned vec_tab [30] = '{11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21, 23, 24, 33, 38, 39,
    40, 41, 59, 60, 64, 65, 66, 69, 70, 89, 90, 133, 139, 140};
  bit          dma_tab [30] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 0, 1, 1, 1, 1, 1, 1, 1,
    1, 1, 1, 1, 1, 1, 1, 0, 0};
  ivmap_core dut_u (.clk(clk), .reset_n(reset_n), .src_req(src_req), .dma_done(dma_done),
    .dma_src(dma_src), .fetch_ack(fetch_ack), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_offset(irq_offset), .slot_valid(slot_valid), .priority_slot_select(slot),
    .irq_dma_clearable(dma_clr), .pending(pending));
  ivmap_core_model core_u (.clk(clk), .reset_n(reset_n), .enable(core_en),
    .wait_cycles(wait_cycles), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .fetch_ack(fetch_ack), .last_vec(last_vec));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic dma_clear(input int unsigned s);
    dma_src  = 5'(s);
    dma_done = 1'b1;
    @(negedge clk);
    dma_done = 1'b0;
  endtask
  // bounded wait: a design that never clears shows as a mismatch, not a hang
  task automatic fetch_all();
    core_en = 1'b1;
    for (int k = 0; k < 40 && pending !== 30'h0; k++) @(negedge clk);
    core_en = 1'b0;
    check("pending after fetch", 0, pending);
  endtask
  task automatic one_source(input int i);
    int unsigned v = vec_tab[i];
    logic        dma = dma_tab[i];
    src_req[i] = 1'b1;
    @(negedge clk);
    src_req = '0;
    check("valid", 1, irq_valid);
    check("vector", v, irq_vector);
    check("offset", 10'h3FC - 10'(4 * v), irq_offset);
    check("slot valid", v >= 12, slot_valid);
    check("slot", v >= 12 ? v : 0, slot);
    check("dma clearable", dma, dma_clr);
    dma_clear(i);
    check("pending after dma", !dma, pending[i]);
    if (!dma) begin
      dma_clear(31);
      check("pending after bad index", 1, pending[i]);
      fetch_all();
      check("fetched vector", v, last_vec);
    end
  endtask
  task automatic two_at_once();
    wait_cycles = 4'h3;
    src_req[14] = 1'b1;
    src_req[29] = 1'b1;
    @(negedge clk);
    src_req = '0;
    check("first vector", 38, irq_vector);
    core_en = 1'b1;
    for (int k = 0; k < 20 && pending[14] !== 1'b0; k++) @(negedge clk);
    core_en = 1'b0;
    repeat (2) @(negedge clk);
    check("second vector", 140, irq_vector);
    check("first fetched", 38, last_vec);
    fetch_all();
    check("second fetched", 140, last_vec);
  endtask
  // a request landing with its own dma clear must stay pending
  task automatic set_beats_clear();
    src_req[21] = 1'b1;
    @(negedge clk);
    dma_src  = 5'd21;
    dma_done = 1'b1;
    @(negedge clk);
    src_req  = '0;
    dma_done = 1'b0;
    check("pending set over clear", 1, pending[21]);
    dma_clear(21);
    check("pending after clear", 0, pending[21]);
  endtask
  task automatic reset_mid();
    src_req[27] = 1'b1;
    @(negedge clk);
    src_req = '0;
    check("pending before reset", 1, pending[27]);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    check("valid in reset", 0, irq_valid);
    check("pending in reset", 0, pending);
    reset_n = 1'b1;
    @(negedge clk);
    check("valid after reset", 0, irq_valid);
    one_source(27);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
  initial begin
    reset_n = 1'b0;
    src_req = '0;
    dma_done = 1'b0;
    dma_src = 5'h00;
    core_en = 1'b0;
    wait_cycles = 4'h0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("idle valid", 0, irq_valid);
    check("idle pending", 0, pending);
    for (int i = 0; i < 30; i++) one_source(i);
    two_at_once();
    set_beats_clear();
    reset_mid();
    finish_test();
  end
endmodule // tb_interrupt_vector_map
